// >>> pkg/raa_pkg.sv
// Package for the radio alarm aggregator: register map, field layout,
// reset values, timing constants and carrier structs.
// Assumes a 20 MHz system clock and a word-aligned Avalon-MM slave.
package raa_pkg;

  // Clock and hold timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned HOLD_TIME_MS = 1000;
  localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_TIME_MS;
  localparam int unsigned HOLD_W = 25;

  // Low-rate loss qualification, in bit intervals
  localparam logic [7:0] LR_LOSS_BITS = 8'hAF;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_EVENT = 4'h8;
  localparam logic [3:0] OFS_MASK = 4'hC;

  // Control register bit positions
  localparam int unsigned CTL_DIS_HR = 0;
  localparam int unsigned CTL_DIS_LR = 1;
  localparam int unsigned CTL_DIS_AIS = 2;
  localparam int unsigned CTL_W = 3;

  // Alarm channel positions in status, event and mask
  localparam int unsigned CH_HR = 0;
  localparam int unsigned CH_LR = 1;
  localparam int unsigned CH_BER = 2;
  localparam int unsigned CH_AIS = 3;
  localparam int unsigned CH_FAN = 4;
  localparam int unsigned CH_FAR = 5;
  localparam int unsigned CH_SUM = 6;
  localparam int unsigned CH_OOS = 7;
  localparam int unsigned NCH = 8;

  // Reset values
  localparam logic [CTL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [NCH-1:0] MASK_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Raw alarm conditions from the radio
  typedef struct packed {
    logic hr_loss;
    logic lr_below;
    logic lr_bit_tick;
    logic ber_degraded;
    logic ber_excessive;
    logic rx_sync_lost;
    logic radio_fail;
    logic [1:0] fan_fail;
    logic far_end_alarm;
    logic loopback_en;
  } raa_cond_t;

  // Active-low individual alarm outputs
  typedef struct packed {
    logic high_rate_input_loss_n;
    logic low_rate_input_loss_n;
    logic ber_n;
    logic indication_signal_insert_alarm_n;
    logic fan_n;
    logic far_end_n;
  } raa_ind_t;

  localparam raa_ind_t IND_RST = 6'h3F;

  // Avalon-MM slave request and answer
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } raa_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } raa_avs_rsp_t;

  // Hold stretcher state
  typedef struct packed {
    logic [HOLD_W-1:0] cnt;
    logic act;
  } raa_hold_st_t;

  // Top-level state
  typedef struct packed {
    raa_cond_t s1;
    raa_cond_t s2;
    logic [7:0] lr_cnt;
    logic [NCH-1:0] held_d;
    logic [CTL_W-1:0] ctrl;
    logic [NCH-1:0] evt;
    logic [NCH-1:0] mask;
    raa_ind_t alm_n;
    logic sum_relay;
    logic oos_relay;
    logic ais_far;
    logic ais_ins;
    logic irq;
    raa_avs_rsp_t rsp;
  } raa_st_t;

endpackage : raa_pkg

// >>> rtl/raa_hold.sv
// Minimum-hold stretcher for one alarm channel.
// Assumes a condition already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module raa_hold #(
  parameter int unsigned HOLD_CYCLES = raa_pkg::HOLD_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cond,
  output logic act
);
  import raa_pkg::*;

  localparam logic [HOLD_W-1:0] RELOAD = HOLD_W'(HOLD_CYCLES - 1);

  raa_hold_st_t st_r;
  raa_hold_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (cond) begin
      // Reload while the condition stands: the hold counts from its end
      st_nxt.cnt = RELOAD; // [R12]
      st_nxt.act = 1'b1;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - HOLD_W'(1);
      st_nxt.act = 1'b1;
    end else begin
      st_nxt.act = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign act = st_r.act;

endmodule : raa_hold

`default_nettype wire

// >>> rtl/raa_top.sv
// Alarm gathering for a point-to-point radio terminal: individual
// active-low alarm outputs, two summary relay drives, AIS controls,
// and an Avalon-MM register slave with a level interrupt.
// Assumes condition inputs synchronous to clk; relay drivers outside.
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Individual alarm outputs are low in alarm
// R2 - Summary relay: any near-end alarm or loopback
// R3 - Out-of-service relay: sync loss, radio fail, loopback
// R4 - High-rate input loss alarm, switch disableable
// R5 - Low-rate loss after 175 bits, clears immediately
// R6 - Send AIS far while low-rate loss; disableable
// R7 - Error-rate alarm above degradation threshold
// R8 - AIS alarm on high errors or sync loss
// R9 - Fan alarm when either fan stops
// R10 - Far-end alarm follows far radio status
// R11 - Relay drives energise contacts when in alarm
// R12 - Alarms hold one second minimum
// R13 - Synchronise inputs; one hold counter per alarm channel, AIS outputs share the LR and AIS counters
module raa_top #(
  parameter int unsigned HOLD_CYCLES = raa_pkg::HOLD_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire raa_pkg::raa_avs_req_t avs_req,
  output raa_pkg::raa_avs_rsp_t avs_rsp,
  input wire raa_pkg::raa_cond_t cond_in,
  output raa_pkg::raa_ind_t alarm_n,
  output logic summary_relay,
  output logic oos_relay,
  output logic ais_to_far,
  output logic ais_insert_local,
  output logic irq
);
  import raa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State

  raa_st_t st_r;
  raa_st_t st_nxt;

  logic [NCH-1:0] raw;
  logic [NCH-1:0] held;
  logic lr_loss_raw;

  ////////////////////////////////////////////////////////////////////////
  // Raw alarm conditions, from the second synchroniser stage only

  always_comb begin
    lr_loss_raw = st_r.s2.lr_below && (st_r.lr_cnt >= LR_LOSS_BITS); // [R5]
    raw = '0;
    raw[CH_HR] = st_r.s2.hr_loss && !st_r.ctrl[CTL_DIS_HR]; // [R4]
    raw[CH_LR] = lr_loss_raw && !st_r.ctrl[CTL_DIS_LR]; // [R6]
    raw[CH_BER] = st_r.s2.ber_degraded; // [R7]
    raw[CH_AIS] = (st_r.s2.ber_excessive || st_r.s2.rx_sync_lost)
                  && !st_r.ctrl[CTL_DIS_AIS]; // [R8]
    raw[CH_FAN] = |st_r.s2.fan_fail; // [R9]
    raw[CH_FAR] = st_r.s2.far_end_alarm; // [R10]
    // Front panel set: every near-end alarm plus sync, radio fail and loopback
    raw[CH_SUM] = raw[CH_HR] || raw[CH_LR] || raw[CH_BER]
                  || raw[CH_AIS] || raw[CH_FAN]
                  || st_r.s2.rx_sync_lost || st_r.s2.radio_fail
                  || st_r.s2.loopback_en; // [R2]
    raw[CH_OOS] = st_r.s2.rx_sync_lost || st_r.s2.radio_fail
                  || st_r.s2.loopback_en; // [R3]
  end

  ////////////////////////////////////////////////////////////////////////
  // One hold stretcher per alarm output

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_hold
      raa_hold #(
        .HOLD_CYCLES(HOLD_CYCLES)
      ) u_hold (
        .clk(clk),
        .srst(srst),
        .cond(raw[gi]),
        .act(held[gi])
      ); // [R13]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic acc;
  logic wr_ok;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] clr;
  logic [NCH-1:0] evt_n;
  logic [31:0] rd;

  always_comb begin
    st_nxt = st_r;

    // Two-flop synchroniser; first stage feeds only the second
    st_nxt.s1 = cond_in; // [R13]
    st_nxt.s2 = st_r.s1; // [R13]

    // Consecutive below-threshold bit intervals, saturating
    if (!st_r.s2.lr_below) begin
      st_nxt.lr_cnt = 8'h00; // [R5]
    end else if (st_r.s2.lr_bit_tick && st_r.lr_cnt < LR_LOSS_BITS) begin
      st_nxt.lr_cnt = st_r.lr_cnt + 8'h01; // [R5]
    end

    // Outputs registered from held alarms
    st_nxt.alm_n.high_rate_input_loss_n = !held[CH_HR]; // [R1]
    st_nxt.alm_n.low_rate_input_loss_n = !held[CH_LR]; // [R1]
    st_nxt.alm_n.ber_n = !held[CH_BER]; // [R1]
    st_nxt.alm_n.indication_signal_insert_alarm_n = !held[CH_AIS]; // [R1]
    st_nxt.alm_n.fan_n = !held[CH_FAN]; // [R1]
    st_nxt.alm_n.far_end_n = !held[CH_FAR]; // [R1]
    // High energises the relay: NO closes, NC opens
    st_nxt.sum_relay = held[CH_SUM]; // [R11]
    st_nxt.oos_relay = held[CH_OOS]; // [R11]
    st_nxt.ais_far = held[CH_LR]; // [R6]
    st_nxt.ais_ins = held[CH_AIS]; // [R8]

    // Events: rising edge of each held alarm
    st_nxt.held_d = held;
    rise = held & ~st_r.held_d;

    // Avalon-MM: one wait cycle, then the answer
    acc = avs_req.read || avs_req.write;
    wr_ok = avs_req.write && !st_r.rsp.waitrequest
            && avs_req.byteenable[0];
    st_nxt.rsp.waitrequest = !(acc && st_r.rsp.waitrequest);

    rd = 32'h0000_0000;
    case (avs_req.address)
      OFS_CTRL: rd[CTL_W-1:0] = st_r.ctrl;
      OFS_STATUS: rd[NCH-1:0] = held;
      OFS_EVENT: rd[NCH-1:0] = st_r.evt;
      OFS_MASK: rd[NCH-1:0] = st_r.mask;
      default: rd = 32'h0000_0000;
    endcase
    if (avs_req.read && st_r.rsp.waitrequest) begin
      st_nxt.rsp.readdata = rd;
    end

    clr = '0;
    if (wr_ok) begin
      case (avs_req.address)
        OFS_CTRL: st_nxt.ctrl = avs_req.writedata[CTL_W-1:0];
        OFS_EVENT: clr = avs_req.writedata[NCH-1:0];
        OFS_MASK: st_nxt.mask = avs_req.writedata[NCH-1:0];
        default: clr = '0;
      endcase
    end

    // Set beats a simultaneous write-one clear
    evt_n = (st_r.evt & ~clr) | rise;
    st_nxt.evt = evt_n;
    st_nxt.irq = |(evt_n & st_nxt.mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.mask <= MASK_RST;
      st_r.alm_n <= IND_RST;
      st_r.rsp.waitrequest <= 1'b1;
      st_r.rsp.readdata <= RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign avs_rsp = st_r.rsp;
  assign alarm_n = st_r.alm_n;
  assign summary_relay = st_r.sum_relay;
  assign oos_relay = st_r.oos_relay;
  assign ais_to_far = st_r.ais_far;
  assign ais_insert_local = st_r.ais_ins;
  assign irq = st_r.irq;

endmodule : raa_top

`default_nettype wire

// >>> tb/raa_chk.sv
// Port checker for the alarm aggregator top.
// Assumes disable bits stay clear while fan, far and relay causes apply.
`timescale 1ns/1ps
`default_nettype none
module raa_chk #(
  parameter int unsigned HOLD_CYCLES = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire raa_pkg::raa_avs_req_t avs_req,
  input wire raa_pkg::raa_avs_rsp_t avs_rsp,
  input wire raa_pkg::raa_cond_t cond_in,
  input wire raa_pkg::raa_ind_t alarm_n,
  input wire logic summary_relay,
  input wire logic oos_relay,
  input wire logic ais_to_far,
  input wire logic ais_insert_local,
  input wire logic irq
);
  import raa_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////
  a_fan_low: assert property (
    |cond_in.fan_fail |-> ##4 !alarm_n.fan_n) else $error("fan late");
  a_far_follow: assert property (
    cond_in.far_end_alarm |-> ##4 !alarm_n.far_end_n) else $error("far late");
  a_ber_low: assert property (
    cond_in.ber_degraded |-> ##4 !alarm_n.ber_n) else $error("ber late");
  a_oos_cause: assert property (
    cond_in.rx_sync_lost | cond_in.radio_fail | cond_in.loopback_en
    |-> ##4 oos_relay) else $error("oos late");
  a_oos_only: assert property (
    $rose(oos_relay) |-> $past(cond_in.rx_sync_lost | cond_in.radio_fail
    | cond_in.loopback_en, 4)) else $error("oos without cause");
  a_sum_loop: assert property (
    cond_in.loopback_en |-> ##4 summary_relay) else $error("summary late");
  a_hold_min: assert property (
    $fell(alarm_n.fan_n) |-> !alarm_n.fan_n [*8]) else $error("hold short");
  // Counts fan alarm cycles so the whole hold is checked, not just 8
  int unsigned fan_low_cnt;
  always_ff @(posedge clk) begin
    if (srst || alarm_n.fan_n) begin
      fan_low_cnt <= 0;
    end else if (fan_low_cnt < HOLD_CYCLES) begin
      fan_low_cnt <= fan_low_cnt + 1;
    end
  end
  a_hold_full: assert property (
    $rose(alarm_n.fan_n) |-> $past(fan_low_cnt) >= HOLD_CYCLES - 1)
    else $error("fan hold shorter than minimum");
  a_ais_pair: assert property (
    ais_insert_local == !alarm_n.indication_signal_insert_alarm_n
    && ais_to_far == !alarm_n.low_rate_input_loss_n) else $error("ais split");
  a_bus_answer: assert property (
    (avs_req.read | avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest ##1 avs_rsp.waitrequest) else $error("bus");
  cover property (oos_relay);
  cover property (!alarm_n.low_rate_input_loss_n);
  cover property (irq);
endmodule : raa_chk
bind raa_top raa_chk #(.HOLD_CYCLES(HOLD_CYCLES)) raa_chk_i (.clk(clk),
  .srst(srst), .avs_req(avs_req), .avs_rsp(avs_rsp), .cond_in(cond_in),
  .alarm_n(alarm_n), .summary_relay(summary_relay), .oos_relay(oos_relay),
  .ais_to_far(ais_to_far), .ais_insert_local(ais_insert_local), .irq(irq));
`default_nettype wire

// >>> tb/raa_mon.sv
// Alarm monitor model: contact states of the two relays.
// Assumes relay drives are high while energised.
`timescale 1ns/1ps
`default_nettype none
module raa_mon (
  input wire logic summary_relay,
  input wire logic oos_relay,
  output logic sum_no_closed,
  output logic oos_nc_closed
);
  assign sum_no_closed = summary_relay;
  assign oos_nc_closed = !oos_relay;
endmodule : raa_mon
`default_nettype wire

// >>> tb/radio_alarm_aggregator_bench.sv
// Bench: reset, then a table of condition cases, hold, registers,
// interrupt, low-rate count, disables and a mid-run reset.
// Assumes the slave answers each access well inside the timeout.
`timescale 1ns/1ps
`default_nettype none
module radio_alarm_aggregator_bench;
  import raa_pkg::*;
  localparam int unsigned HC = 16;
  typedef struct packed {
    raa_cond_t c;
    raa_ind_t a;
    logic s;
    logic o;
  } raa_row_t;
  logic clk, srst, summary_relay, oos_relay, ais_to_far, ais_insert_local;
  logic irq, no_c, nc_c;
  raa_avs_req_t avs_req;
  raa_avs_rsp_t avs_rsp;
  raa_cond_t cond_in;
  raa_ind_t alarm_n;
  logic [31:0] q;
  int miscompares, comparisons, cyc;
  raa_row_t rows [9] = '{'{11'h004, 6'h3D, 1'b1, 1'b0},
    '{11'h008, 6'h3D, 1'b1, 1'b0}, '{11'h002, 6'h3E, 1'b0, 1'b0},
    '{11'h080, 6'h37, 1'b1, 1'b0}, '{11'h040, 6'h3B, 1'b1, 1'b0},
    '{11'h020, 6'h3B, 1'b1, 1'b1}, '{11'h010, 6'h3F, 1'b1, 1'b1},
    '{11'h001, 6'h3F, 1'b1, 1'b1}, '{11'h400, 6'h1F, 1'b1, 1'b0}};
  raa_top #(.HOLD_CYCLES(HC)) raa_top_i (.clk(clk), .srst(srst),
    .avs_req(avs_req), .avs_rsp(avs_rsp), .cond_in(cond_in),
    .alarm_n(alarm_n), .summary_relay(summary_relay), .oos_relay(oos_relay),
    .ais_to_far(ais_to_far), .ais_insert_local(ais_insert_local), .irq(irq));
  raa_mon raa_mon_i (.summary_relay(summary_relay), .oos_relay(oos_relay),
    .sum_no_closed(no_c), .oos_nc_closed(nc_c));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_req <= '{a, !w, w, d, 4'hF};
    do @(posedge clk); while (avs_rsp.waitrequest !== 1'b0);
    q = avs_rsp.readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask : bus
  task drive(input logic [10:0] c, input int n);
    cond_in <= c;
    repeat (n) @(posedge clk);
  endtask : drive
  task conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Ceiling well above the thousand or so cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    srst = 1'b1;
    avs_req = '0;
    cond_in = '0;
    miscompares = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    chk("reset", 32'({alarm_n, summary_relay, oos_relay, irq}), 32'h01F8);
    srst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", q, 32'h0);
    bus(1'b0, OFS_MASK, 32'h0);
    chk("mask", q, 32'h0);
    foreach (rows[i]) begin
      drive(rows[i].c, 8);
      chk("alarms", 32'({alarm_n, summary_relay, oos_relay}), 32'(rows[i][7:0]));
      chk("contacts", 32'({no_c, nc_c}), 32'({rows[i].s, !rows[i].o}));
      chk("ais local", 32'(ais_insert_local), 32'(!rows[i].a[2]));
      drive(11'h000, HC + 8);
      chk("idle", 32'(alarm_n), 32'h3F);
    end
    $display("table done");
    bus(1'b1, OFS_EVENT, 32'hFF);
    bus(1'b1, OFS_MASK, 32'h10);
    bus(1'b0, OFS_MASK, 32'h0);
    chk("mask rw", q, 32'h10);
    drive(11'h004, 1);
    drive(11'h002, 6);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", q, 32'h70);
    chk("irq", 32'(irq), 32'h1);
    drive(11'h000, HC - 12);
    chk("held fan", 32'(alarm_n.fan_n), 32'h0);
    repeat (12) @(posedge clk);
    chk("fan off", 32'(alarm_n.fan_n), 32'h1);
    bus(1'b1, OFS_EVENT, 32'h50);
    repeat (2) @(posedge clk);
    chk("irq off", 32'(irq), 32'h0);
    bus(1'b0, OFS_EVENT, 32'h0);
    chk("masked evt", q, 32'h20);
    // After a nonzero read, so stale read data would show
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("hold and irq done");
    // Low-rate loss needs exactly the documented tick count
    for (int k = 1; k <= 175; k++) begin
      drive(11'h300, 1);
      drive(11'h200, 1);
      if (k >= 174) begin
        repeat (6) @(posedge clk);
        chk("lr", 32'({alarm_n, ais_to_far}), k == 175 ? 32'h5F : 32'h7E);
      end
    end
    drive(11'h000, HC + 8);
    chk("lr clear", 32'({alarm_n, ais_to_far}), 32'h7E);
    $display("low rate done");
    bus(1'b1, OFS_CTRL, 32'h7);
    // Long enough for the low-rate count to pass its threshold
    drive(11'h740, 200);
    chk("disabled", 32'({alarm_n, ais_insert_local, ais_to_far, summary_relay}), 32'h01F8);
    drive(11'h000, HC + 8);
    $display("disables done");
    // Reset while alarms stand and ctrl, mask and events are nonzero
    drive(11'h020, 8);
    srst <= 1'b1;
    drive(11'h000, 5);
    chk("mid reset", 32'({alarm_n, summary_relay, oos_relay, irq}), 32'h01F8);
    srst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h0);
    bus(1'b0, OFS_MASK, 32'h0);
    chk("mask reset", q, 32'h0);
    bus(1'b0, OFS_EVENT, 32'h0);
    chk("event reset", q, 32'h0);
    $display("reset done");
    conclude();
  end
endmodule : radio_alarm_aggregator_bench
`default_nettype wire
